//--- acx_executor.sv
// ata card command executor with apb task-file access
// Operation
// [RULE1] feature 01H byte port, 81H word port
// [RULE2] feature 55H disables read look-ahead
// [RULE3] CCH soft reset restores defaults, 66H keeps
// [RULE4] feature BBH selects four long bytes
// [RULE5] C6H enables multiple, latches block size
// [RULE6] sleep command: busy, sleep, ready, interrupt
// [RULE7] standby commands: busy, sleep, immediate interrupt
// [RULE8] translate reports erase count as zero
// [RULE9] wear level is nop, count 00H
// [RULE10] write buffer fills buffer, no media
// [RULE11] long write carries 516-byte sectors
// [RULE12] write multiple interrupts once per block
// [RULE13] multiple write without erase skips erase
// [RULE14] sector write 1..256 sectors, zero 256
// [RULE15] 38H sector write skips erase
// [RULE16] write verify checks each sector after program
// [RULE17] ready within 100 ms after reset
// [RULE18] sleep to idle within 2 ms
// [RULE19] drq within 2 ms of command
// [RULE20] ready about 2 ms after sector data
// [RULE21] host loads feature then issues EFH
// [RULE22] unknown sub-code aborts with error
// [RULE23] drq per sector, one sector moved
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
module acx_executor
    import acx_pkg::*;
#(
    parameter int RESET_CYC = RESET_READY_CYC,
    parameter int WAKE_CYC = WAKE_MAX_CYC,
    parameter int PROG_CYC = SECTOR_READY_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic intrq
);
    acx_state_t state_ff;
    acx_phase_t phase_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic intrq_ff;
    logic [23:0] timer_ff;
    logic [7:0] feat_ff;
    logic [7:0] err_reg_ff;
    logic err_ff;
    logic [7:0] sc_ff;
    logic [7:0] sn_ff;
    logic [7:0] cyl_lo_ff;
    logic [7:0] cyl_hi_ff;
    logic [7:0] dh_ff;
    logic [7:0] cmd_ff;
    logic byte_mode_ff;
    logic lookahead_ff;
    logic keep_ff;
    logic long4_ff;
    logic mult_en_ff;
    logic [7:0] mult_blk_ff;
    logic [8:0] left_ff;
    logic [7:0] blk_cnt_ff;
    logic [9:0] bcnt_ff;
    logic [9:0] sec_len_ff;
    logic erase_ff;
    logic verify_ff;
    logic media_ff;
    logic per_blk_ff;
    logic [15:0] media_cnt_ff;
    logic [8:0] peek_ff;
    logic [15:0] buf_mem [0:BUF_WORDS-1];
    logic [31:0] nxt_rdata;
    logic [15:0] peek_word;
    logic bsy;
    logic [7:0] status;
    logic acc_wr;
    logic acc_rd;
    logic setup;
    logic map_hit;
    logic [7:0] wr_byte;
    logic [8:0] wr_idx;

    // register offset match
    function automatic logic hit(input logic [31:0] addr, input logic [7:0] ofs);
        hit = (addr[31:8] == 24'h000000) && (addr[7:0] == ofs);
    endfunction

    assign setup = psel & ~penable & ~pready_ff;
    assign acc_wr = psel & penable & pready_ff & pwrite & ~pslverr_ff;
    assign acc_rd = psel & penable & pready_ff & ~pwrite & ~pslverr_ff;
    assign bsy = (state_ff == ST_RESET) || (state_ff == ST_EXEC) || (state_ff == ST_OVH)
        || (state_ff == ST_MEDIA) || (state_ff == ST_WAKE);
    assign status = {bsy, (state_ff == ST_IDLE) || (state_ff == ST_SLEEP), 2'b00,
        (state_ff == ST_DRQ), 2'b00, err_ff};
    assign wr_byte = pwdata[7:0];
    assign wr_idx = bcnt_ff[9:1];
    assign peek_word = (peek_ff < 9'(BUF_WORDS)) ? buf_mem[peek_ff] : 16'h0000;
    assign map_hit = hit(paddr, OFS_DATA) || hit(paddr, OFS_FEAT_ERR)
        || hit(paddr, OFS_SEC_CNT) || hit(paddr, OFS_SEC_NUM) || hit(paddr, OFS_CYL_LO)
        || hit(paddr, OFS_CYL_HI) || hit(paddr, OFS_DRV_HEAD) || hit(paddr, OFS_CMD_STAT)
        || hit(paddr, OFS_CTRL_CFG) || hit(paddr, OFS_MEDIA_CNT) || hit(paddr, OFS_BUF_PEEK);

    // read data mux, sampled in the setup cycle
    always_comb
    begin
        nxt_rdata = 32'h00000000;
        if (hit(paddr, OFS_FEAT_ERR))
            nxt_rdata = {24'h000000, err_reg_ff};
        else if (hit(paddr, OFS_SEC_CNT))
            nxt_rdata = {24'h000000, sc_ff};
        else if (hit(paddr, OFS_SEC_NUM))
            nxt_rdata = {24'h000000, sn_ff};
        else if (hit(paddr, OFS_CYL_LO))
            nxt_rdata = {24'h000000, cyl_lo_ff};
        else if (hit(paddr, OFS_CYL_HI))
            nxt_rdata = {24'h000000, cyl_hi_ff};
        else if (hit(paddr, OFS_DRV_HEAD))
            nxt_rdata = {24'h000000, dh_ff};
        else if (hit(paddr, OFS_CMD_STAT))
            nxt_rdata = {24'h000000, status};
        else if (hit(paddr, OFS_CTRL_CFG))
            nxt_rdata = {16'h0000, mult_blk_ff, 3'b000, mult_en_ff, long4_ff, keep_ff,
                lookahead_ff, byte_mode_ff};
        else if (hit(paddr, OFS_MEDIA_CNT))
            nxt_rdata = {16'h0000, media_cnt_ff};
        else if (hit(paddr, OFS_BUF_PEEK))
            nxt_rdata = {7'h00, peek_ff, peek_word};
    end

    // apb slave, no wait states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end
        else
        begin
            pready_ff <= setup;
            pslverr_ff <= setup & ~map_hit;
            prdata_ff <= setup ? nxt_rdata : 32'h00000000;
        end
    end

    // buffer peek pointer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            peek_ff <= 9'h000;
        else if (acc_wr && hit(paddr, OFS_BUF_PEEK))
            peek_ff <= pwdata[24:16];
    end

    // sector buffer fill, low byte first in byte mode
    always_ff @(posedge pclk)
    begin
        if (acc_wr && hit(paddr, OFS_DATA) && state_ff == ST_DRQ)
        begin
            if (!byte_mode_ff)
                buf_mem[wr_idx] <= pwdata[15:0]; // [RULE1]
            else if (bcnt_ff[0])
                buf_mem[wr_idx] <= {wr_byte, buf_mem[wr_idx][7:0]}; // [RULE1]
            else
                buf_mem[wr_idx] <= {8'h00, wr_byte};
        end
    end

    // interrupt, a set wins over the read clear
    logic irq_set;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            intrq_ff <= 1'b0;
        else if (irq_set)
            intrq_ff <= 1'b1;
        else if (acc_rd && hit(paddr, OFS_CMD_STAT))
            intrq_ff <= 1'b0;
    end

    // sector end: next sector or done
    logic last_sec;
    logic blk_end;
    assign last_sec = (left_ff == 9'd1);
    assign blk_end = ~per_blk_ff || (blk_cnt_ff + 8'd1 == mult_blk_ff) || last_sec; // [RULE12]
    assign irq_set = (state_ff == ST_EXEC && !(cmd_ff inside {CMD_WR_BUF, CMD_WR_LONG_A,
        CMD_WR_LONG_B, CMD_WR_MULT, CMD_WR_MULT_NE, CMD_WR_SEC_A, CMD_WR_SEC_B,
        CMD_WR_SEC_NE, CMD_WR_VERIFY}))
        || (state_ff == ST_DRQ && !media_ff
            && bcnt_ff + (byte_mode_ff ? 10'd1 : 10'd2) >= sec_len_ff
            && acc_wr && hit(paddr, OFS_DATA))
        || (state_ff == ST_MEDIA && timer_ff == 24'h000000 && blk_end
            && (phase_ff == PH_VERIFY || (phase_ff == PH_PROG && !verify_ff)));

    // command executor
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= ST_RESET;
            phase_ff <= PH_PROG;
            timer_ff <= 24'(RESET_CYC); // [RULE17]
            feat_ff <= 8'h00;
            err_reg_ff <= 8'h00;
            err_ff <= 1'b0;
            sc_ff <= 8'h01;
            sn_ff <= 8'h01;
            cyl_lo_ff <= 8'h00;
            cyl_hi_ff <= 8'h00;
            dh_ff <= 8'h00;
            cmd_ff <= 8'h00;
            byte_mode_ff <= 1'b0;
            lookahead_ff <= 1'b1;
            keep_ff <= 1'b0;
            long4_ff <= 1'b0;
            mult_en_ff <= 1'b0;
            mult_blk_ff <= 8'h00;
            left_ff <= 9'h000;
            blk_cnt_ff <= 8'h00;
            bcnt_ff <= 10'h000;
            sec_len_ff <= SECTOR_BYTES;
            erase_ff <= 1'b0;
            verify_ff <= 1'b0;
            media_ff <= 1'b0;
            per_blk_ff <= 1'b0;
            media_cnt_ff <= 16'h0000;
        end
        else if (acc_wr && hit(paddr, OFS_CTRL_CFG) && pwdata[CTRL_SRST])
        begin
            state_ff <= ST_RESET;
            timer_ff <= 24'(RESET_CYC); // [RULE17]
            if (!keep_ff)
            begin
                byte_mode_ff <= 1'b0; // [RULE3]
                lookahead_ff <= 1'b1;
                long4_ff <= 1'b0;
                mult_en_ff <= 1'b0;
                mult_blk_ff <= 8'h00;
            end
        end
        else
        begin
            // task file is writable whenever the card is not busy
            if (acc_wr && !bsy)
            begin
                if (hit(paddr, OFS_FEAT_ERR))
                    feat_ff <= pwdata[7:0]; // [RULE21]
                if (hit(paddr, OFS_SEC_CNT))
                    sc_ff <= pwdata[7:0];
                if (hit(paddr, OFS_SEC_NUM))
                    sn_ff <= pwdata[7:0];
                if (hit(paddr, OFS_CYL_LO))
                    cyl_lo_ff <= pwdata[7:0];
                if (hit(paddr, OFS_CYL_HI))
                    cyl_hi_ff <= pwdata[7:0];
                if (hit(paddr, OFS_DRV_HEAD))
                    dh_ff <= pwdata[7:0];
            end
            unique case (state_ff)
                ST_RESET, ST_OVH, ST_WAKE:
                begin
                    if (timer_ff != 24'h000000)
                        timer_ff <= timer_ff - 24'd1;
                    else if (state_ff == ST_RESET)
                        state_ff <= ST_IDLE;
                    else if (state_ff == ST_WAKE)
                        state_ff <= ST_EXEC; // [RULE18]
                    else
                    begin
                        state_ff <= ST_DRQ; // [RULE19]
                        bcnt_ff <= 10'h000;
                    end
                end
                ST_IDLE, ST_SLEEP:
                begin
                    if (acc_wr && hit(paddr, OFS_CMD_STAT))
                    begin
                        cmd_ff <= pwdata[7:0];
                        err_ff <= 1'b0;
                        err_reg_ff <= 8'h00;
                        state_ff <= (state_ff == ST_SLEEP) ? ST_WAKE : ST_EXEC;
                        timer_ff <= 24'(WAKE_CYC); // [RULE18]
                    end
                end
                ST_EXEC:
                begin
                    state_ff <= ST_IDLE;
                    timer_ff <= 24'(CMD_OVH_CYC); // [RULE19]
                    left_ff <= (sc_ff == 8'h00) ? 9'd256 : {1'b0, sc_ff}; // [RULE14]
                    blk_cnt_ff <= 8'h00;
                    sec_len_ff <= SECTOR_BYTES;
                    erase_ff <= 1'b1;
                    verify_ff <= 1'b0;
                    media_ff <= 1'b1;
                    per_blk_ff <= 1'b0;
                    unique case (cmd_ff)
                        CMD_SET_FEAT:
                        begin
                            unique case (feat_ff)
                                FEAT_BYTE_ON: byte_mode_ff <= 1'b1; // [RULE1]
                                FEAT_BYTE_OFF: byte_mode_ff <= 1'b0; // [RULE1]
                                FEAT_LOOKAHEAD_OFF: lookahead_ff <= 1'b0; // [RULE2]
                                FEAT_KEEP_ON_SRST: keep_ff <= 1'b1; // [RULE3]
                                FEAT_POR_ON_SRST: keep_ff <= 1'b0; // [RULE3]
                                FEAT_LONG_4: long4_ff <= 1'b1; // [RULE4]
                                default:
                                begin
                                    err_ff <= 1'b1; // [RULE22]
                                    err_reg_ff[ERR_ABRT] <= 1'b1; // [RULE22]
                                end
                            endcase
                        end
                        CMD_SET_MULT:
                        begin
                            mult_en_ff <= (sc_ff != 8'h00); // [RULE5]
                            mult_blk_ff <= sc_ff; // [RULE5]
                        end
                        CMD_SLEEP_A, CMD_SLEEP_B:
                            state_ff <= ST_SLEEP; // [RULE6]
                        CMD_STBY_A, CMD_STBY_B, CMD_STBY_IMM_A, CMD_STBY_IMM_B:
                            state_ff <= ST_SLEEP; // [RULE7]
                        CMD_TRANSLATE:
                            sc_ff <= ERASE_CNT_ZERO; // [RULE8]
                        CMD_WEAR:
                            sc_ff <= WEAR_DONE_CNT; // [RULE9]
                        CMD_WR_BUF:
                        begin
                            state_ff <= ST_OVH;
                            media_ff <= 1'b0; // [RULE10]
                        end
                        CMD_WR_LONG_A, CMD_WR_LONG_B:
                        begin
                            state_ff <= ST_OVH;
                            sec_len_ff <= SECTOR_BYTES + ECC_BYTES; // [RULE11] [RULE4]
                        end
                        CMD_WR_MULT, CMD_WR_MULT_NE:
                        begin
                            if (mult_en_ff)
                            begin
                                state_ff <= ST_OVH;
                                per_blk_ff <= 1'b1; // [RULE12]
                                erase_ff <= (cmd_ff == CMD_WR_MULT); // [RULE13]
                            end
                            else
                            begin
                                err_ff <= 1'b1;
                                err_reg_ff[ERR_ABRT] <= 1'b1;
                            end
                        end
                        CMD_WR_SEC_A, CMD_WR_SEC_B:
                            state_ff <= ST_OVH; // [RULE14]
                        CMD_WR_SEC_NE:
                        begin
                            state_ff <= ST_OVH;
                            erase_ff <= 1'b0; // [RULE15]
                        end
                        CMD_WR_VERIFY:
                        begin
                            state_ff <= ST_OVH;
                            verify_ff <= 1'b1; // [RULE16]
                        end
                        default:
                        begin
                            err_ff <= 1'b1;
                            err_reg_ff[ERR_ABRT] <= 1'b1;
                        end
                    endcase
                end
                ST_DRQ:
                begin
                    if (acc_wr && hit(paddr, OFS_DATA))
                    begin
                        bcnt_ff <= bcnt_ff + (byte_mode_ff ? 10'd1 : 10'd2); // [RULE23]
                        if (bcnt_ff + (byte_mode_ff ? 10'd1 : 10'd2) >= sec_len_ff)
                        begin
                            state_ff <= media_ff ? ST_MEDIA : ST_IDLE; // [RULE23] [RULE10]
                            phase_ff <= erase_ff ? PH_ERASE : PH_PROG;
                            timer_ff <= erase_ff ? 24'(ERASE_CYC) : 24'(PROG_CYC); // [RULE20]
                        end
                    end
                end
                ST_MEDIA:
                begin
                    if (timer_ff != 24'h000000)
                        timer_ff <= timer_ff - 24'd1;
                    else if (phase_ff == PH_ERASE)
                    begin
                        phase_ff <= PH_PROG;
                        timer_ff <= 24'(PROG_CYC); // [RULE20]
                    end
                    else if (phase_ff == PH_PROG && verify_ff)
                    begin
                        phase_ff <= PH_VERIFY; // [RULE16]
                        timer_ff <= 24'(VERIFY_CYC);
                    end
                    else
                    begin
                        media_cnt_ff <= media_cnt_ff + 16'd1;
                        sn_ff <= sn_ff + 8'd1;
                        left_ff <= left_ff - 9'd1; // [RULE14]
                        sc_ff <= sc_ff - 8'd1;
                        blk_cnt_ff <= blk_end ? 8'h00 : blk_cnt_ff + 8'd1; // [RULE12]
                        bcnt_ff <= 10'h000;
                        state_ff <= last_sec ? ST_IDLE : ST_DRQ; // [RULE23]
                    end
                end
            endcase
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign intrq = intrq_ff;
endmodule

//--- acx_executor_asserts.sv
// port checker for the card command executor
`timescale 1ns/1ps
module acx_executor_asserts
    import acx_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic intrq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ready_after_setup_a: assert property ((psel && !penable) |=> pready)
        else $error("no ready after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    unmapped_error_a: assert property ((psel && !penable && (paddr > 32'h28
        || paddr[1:0] != 2'b00)) |=> pslverr)
        else $error("unmapped access not refused");
    mapped_no_error_a: assert property ((psel && !penable && paddr <= 32'h28
        && paddr[1:0] == 2'b00) |=> !pslverr)
        else $error("mapped access refused");
    data_reads_zero_a: assert property ((pready && !pwrite && paddr == 32'h0)
        |-> prdata == 32'h0)
        else $error("data port read not zero");
    drq_not_busy_a: assert property ((pready && !pwrite && paddr == 32'h1C)
        |-> !(prdata[STAT_BSY] && prdata[STAT_DRQ]))
        else $error("busy and data request together");
endmodule
bind acx_executor acx_executor_asserts i_acx_executor_asserts (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .intrq(intrq));

//--- acx_executor_tb.sv
// testbench for the card command executor
`timescale 1ns/1ps
module acx_executor_tb;
    import acx_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, intrq, err, irq_q;
    logic [31:0] paddr, pwdata, prdata, rd;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int irqs = 0;
    int base = 0;
    int media = 0;
    logic [7:0] ft [6] = '{8'h01, 8'h55, 8'h66, 8'hBB, 8'hCC, 8'h81};
    logic [3:0] fe [6] = '{4'h3, 4'h1, 4'h5, 4'hD, 4'h9, 4'h8};
    logic [7:0] wc [8] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h38, 8'h3C, 8'hC5, 8'hCD};
    int ws [8] = '{2, 1, 1, 1, 1, 1, 2, 2};
    int wn [8] = '{256, 256, 258, 258, 256, 256, 256, 256};
    int wi [8] = '{2, 1, 1, 1, 1, 1, 1, 1};
    logic [7:0] sl [6] = '{8'hE6, 8'h99, 8'hE2, 8'h96, 8'hE0, 8'h94};
    always #4 pclk = ~pclk;
    acx_executor #(.RESET_CYC(20), .WAKE_CYC(10), .PROG_CYC(10)) i_acx_executor (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .intrq(intrq));
    acx_host_model i_acx_host_model (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        irq_q <= intrq;
        if (intrq === 1'b1 && irq_q !== 1'b1)
            irqs <= irqs + 1;
        if (cycles == 90000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rr(input logic [7:0] a);
        i_acx_host_model.xfer(1'b0, {24'h0, a}, 32'h0, rd, err);
    endtask
    task automatic ww(input logic [7:0] a, input logic [31:0] d);
        i_acx_host_model.xfer(1'b1, {24'h0, a}, d, rd, err);
    endtask
    // poll status until the masked bits match, bounded
    task automatic wait_st(input logic [7:0] m, input logic [7:0] want);
        int n;
        n = 0;
        rr(OFS_CMD_STAT);
        while ((rd[7:0] & m) !== want && n < 3000)
        begin
            rr(OFS_CMD_STAT);
            n++;
        end
        chk("status", {24'h0, want}, {24'h0, rd[7:0] & m});
        repeat (2) @(posedge pclk);
    endtask
    // issue a command and move whole sectors of data
    task automatic cmd(input logic [7:0] c, input logic [7:0] sc, input int words, input int secs);
        base = irqs;
        ww(OFS_SEC_CNT, {24'h0, sc});
        ww(OFS_CMD_STAT, {24'h0, c});
        for (int s = 0; s < secs; s++)
        begin
            wait_st(8'h88, 8'h08);
            for (int i = 0; i < words; i++)
                ww(OFS_DATA, 32'(i + c));
            rr(OFS_CMD_STAT);
            chk("drq after sector", 32'h0, {31'h0, rd[STAT_DRQ]});
        end
        wait_st(8'h88, 8'h00);
    endtask
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rr(OFS_CMD_STAT);
        chk("busy after reset", 32'h1, {31'h0, rd[STAT_BSY]});
        wait_st(8'hC0, 8'h40);
        rr(OFS_CTRL_CFG);
        chk("config reset", 32'h2, {16'h0, rd[15:0]});
        rr(8'h2C);
        chk("unmapped", 32'h1, {31'h0, err});
        for (int i = 0; i < 6; i++)
        begin
            ww(OFS_FEAT_ERR, {24'h0, ft[i]});
            cmd(CMD_SET_FEAT, 8'h01, 0, 0);
            rr(OFS_CTRL_CFG);
            chk("feature", {28'h0, fe[i]}, {28'h0, rd[3:0]});
        end
        ww(OFS_FEAT_ERR, 32'h12);
        cmd(CMD_SET_FEAT, 8'h01, 0, 0);
        rr(OFS_CMD_STAT);
        chk("error status", 32'h1, {31'h0, rd[STAT_ERR]});
        rr(OFS_FEAT_ERR);
        chk("abort bit", 32'h1, {31'h0, rd[ERR_ABRT]});
        cmd(CMD_SET_MULT, 8'h02, 0, 0);
        rr(OFS_CTRL_CFG);
        chk("multiple", 32'h5, {23'h0, rd[15:8], rd[4]});
        for (int i = 0; i < 2; i++)
        begin
            cmd(i == 0 ? CMD_WEAR : CMD_TRANSLATE, 8'h09, 0, 0);
            rr(OFS_SEC_CNT);
            chk("count zero", 32'h0, {24'h0, rd[7:0]});
        end
        for (int i = 0; i < 8; i++)
        begin
            ww(OFS_SEC_NUM, 32'h5);
            cmd(wc[i], 8'(ws[i]), wn[i], ws[i]);
            media += ws[i];
            chk("interrupts", 32'(wi[i]), 32'(irqs - base));
            rr(OFS_SEC_NUM);
            chk("sector number", 32'(5 + ws[i]), {24'h0, rd[7:0]});
            rr(OFS_MEDIA_CNT);
            chk("media count", 32'(media), {16'h0, rd[15:0]});
        end
        cmd(CMD_WR_BUF, 8'h01, 256, 1);
        ww(OFS_BUF_PEEK, 32'h0005_0000);
        rr(OFS_BUF_PEEK);
        chk("buffer word", 32'hED, {16'h0, rd[15:0]});
        rr(OFS_MEDIA_CNT);
        chk("media count", 32'(media), {16'h0, rd[15:0]});
        for (int i = 0; i < 6; i++)
        begin
            cmd(sl[i], 8'h01, 0, 0);
            chk("sleep interrupt", 32'h1, 32'(irqs - base));
        end
        ww(OFS_CTRL_CFG, 32'h1);
        wait_st(8'hC0, 8'h40);
        rr(OFS_CTRL_CFG);
        chk("soft reset", 32'h2, {16'h0, rd[15:0]});
        end_of_test();
    end
endmodule

//--- acx_host_model.sv
// apb host model driving the card task file
`timescale 1ns/1ps
module acx_host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
    end
    // one transfer, released bus shows inverted values
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= ~w;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

//--- acx_pkg.sv
// constants shared by the card command executor
package acx_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_FEAT_ERR = 8'h04;
    localparam logic [7:0] OFS_SEC_CNT = 8'h08;
    localparam logic [7:0] OFS_SEC_NUM = 8'h0C;
    localparam logic [7:0] OFS_CYL_LO = 8'h10;
    localparam logic [7:0] OFS_CYL_HI = 8'h14;
    localparam logic [7:0] OFS_DRV_HEAD = 8'h18;
    localparam logic [7:0] OFS_CMD_STAT = 8'h1C;
    localparam logic [7:0] OFS_CTRL_CFG = 8'h20;
    localparam logic [7:0] OFS_MEDIA_CNT = 8'h24;
    localparam logic [7:0] OFS_BUF_PEEK = 8'h28;
    // status, error and control bit positions
    localparam int STAT_BSY = 7;
    localparam int STAT_DRDY = 6;
    localparam int STAT_DRQ = 3;
    localparam int STAT_ERR = 0;
    localparam int ERR_ABRT = 2;
    localparam int CTRL_SRST = 0;
    // command codes
    localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
    localparam logic [7:0] CMD_SET_MULT = 8'hC6;
    localparam logic [7:0] CMD_SLEEP_A = 8'hE6;
    localparam logic [7:0] CMD_SLEEP_B = 8'h99;
    localparam logic [7:0] CMD_STBY_A = 8'hE2;
    localparam logic [7:0] CMD_STBY_B = 8'h96;
    localparam logic [7:0] CMD_STBY_IMM_A = 8'hE0;
    localparam logic [7:0] CMD_STBY_IMM_B = 8'h94;
    localparam logic [7:0] CMD_TRANSLATE = 8'h87;
    localparam logic [7:0] CMD_WEAR = 8'hF5;
    localparam logic [7:0] CMD_WR_BUF = 8'hE8;
    localparam logic [7:0] CMD_WR_LONG_A = 8'h32;
    localparam logic [7:0] CMD_WR_LONG_B = 8'h33;
    localparam logic [7:0] CMD_WR_MULT = 8'hC5;
    localparam logic [7:0] CMD_WR_MULT_NE = 8'hCD;
    localparam logic [7:0] CMD_WR_SEC_A = 8'h30;
    localparam logic [7:0] CMD_WR_SEC_B = 8'h31;
    localparam logic [7:0] CMD_WR_SEC_NE = 8'h38;
    localparam logic [7:0] CMD_WR_VERIFY = 8'h3C;
    // set features sub-codes
    localparam logic [7:0] FEAT_BYTE_ON = 8'h01;
    localparam logic [7:0] FEAT_LOOKAHEAD_OFF = 8'h55;
    localparam logic [7:0] FEAT_KEEP_ON_SRST = 8'h66;
    localparam logic [7:0] FEAT_BYTE_OFF = 8'h81;
    localparam logic [7:0] FEAT_LONG_4 = 8'hBB;
    localparam logic [7:0] FEAT_POR_ON_SRST = 8'hCC;
    // sector sizes in bytes, buffer depth in words, reported counts
    localparam logic [9:0] SECTOR_BYTES = 10'd512;
    localparam logic [9:0] ECC_BYTES = 10'd4;
    localparam int BUF_WORDS = 258;
    localparam logic [7:0] WEAR_DONE_CNT = 8'h00;
    localparam logic [7:0] ERASE_CNT_ZERO = 8'h00;
    // timing
    localparam int CLK_KHZ = 125000;
    localparam int RESET_READY_MS = 100;
    localparam int WAKE_MAX_MS = 2;
    localparam int CMD_DRQ_MAX_MS = 2;
    localparam int SECTOR_READY_TYP_MS = 2;
    localparam int RESET_READY_CYC = RESET_READY_MS * CLK_KHZ;
    localparam int WAKE_MAX_CYC = WAKE_MAX_MS * CLK_KHZ;
    localparam int CMD_DRQ_MAX_CYC = CMD_DRQ_MAX_MS * CLK_KHZ;
    localparam int SECTOR_READY_CYC = SECTOR_READY_TYP_MS * CLK_KHZ;
    localparam int ERASE_CYC = 64;
    localparam int VERIFY_CYC = 32;
    localparam int CMD_OVH_CYC = 16;
    // executor states
    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_OVH = 3'b011,
        ST_DRQ = 3'b100,
        ST_MEDIA = 3'b101,
        ST_SLEEP = 3'b110,
        ST_WAKE = 3'b111
    } acx_state_t;
    typedef enum logic [1:0] {
        PH_ERASE = 2'b00,
        PH_PROG = 2'b01,
        PH_VERIFY = 2'b10
    } acx_phase_t;
endpackage
